/* File: pkg/sys_config_defines.svh */
`ifndef SYS_CONFIG_DEFINES_SVH
`define SYS_CONFIG_DEFINES_SVH

// register byte offsets
`define CFG_ZERO_OFFSET 4'h0
`define CFG_ONE_OFFSET 4'h4
`define CFG_TWO_OFFSET 4'h8

// config zero fields
`define CFG0_HIGH_DRIVE_BIT 19
`define CFG0_TIMER_SIXTEEN_BIT 12
`define CFG0_TIMER_FIFTEEN_BIT 11
`define CFG0_SERIAL_RX_BIT 10
`define CFG0_SERIAL_TX_BIT 9
`define CFG0_CONVERTER_BIT 8
`define CFG0_WRITE_MASK 32'h0008_1F00
// config one fields
`define CFG1_WRITE_MASK 32'h0000_000E
// config two fields (parity control)
`define CFG2_PARITY_FLAG_BIT 8
`define CFG2_PARITY_LINK_BIT 1
`define CFG2_WRITE_MASK 32'h0000_0002

`define CFG_RESET_VALUE 32'h0000_0000
`define BOOT_LATCH_EDGE 3'h4

// boot alias bases
`define MAIN_FLASH_BASE 32'h0800_0000
`define SYSTEM_MEMORY_BASE 32'h1FFF_EC00
`define SRAM_BASE 32'h2000_0000

// sram geometry (8 KB of 32-bit words)
`define SRAM_INDEX_WIDTH 11
`define SRAM_WORDS 2048

`endif

/* File: pkg/sys_config_pkg.sv */
package sys_config_pkg;

  typedef enum logic [1:0] {BOOT_MAIN_FLASH, BOOT_SYSTEM_MEMORY, BOOT_ONCHIP_SRAM} boot_source_t;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

  typedef struct packed {
    logic [4:0] timerSixteenCh;
    logic [4:0] timerFifteenCh;
    logic [4:0] serialRxCh;
    logic [4:0] serialTxCh;
    logic [4:0] converterCh;
  } dma_routes_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [3:0] strobe;
    logic write;
    logic valid;
    logic [31:0] wdata;
  } sram_req_t;

endpackage : sys_config_pkg

/* File: core/sys_config_boot_remap.sv */
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
`include "sys_config_defines.svh"

module sys_config_boot_remap
  import sys_config_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  // boot straps
  input wire logic bootSelectPin,
  input wire logic bootAltOptionBit,
  input wire logic parityCheckOption,
  // register bus
  input wire axil_req_t busReq,
  output axil_rsp_t busRsp,
  // processor memory port
  input wire sram_req_t memReq,
  output logic [31:0] memRdata,
  output logic memRvalid,
  output logic [31:0] flashAddr,
  output logic flashSelect,
  output logic sramSelect,
  // dma request routing
  input wire logic timerSixteenReq,
  input wire logic timerFifteenReq,
  input wire logic serialRxReq,
  input wire logic serialTxReq,
  input wire logic converterReq,
  output dma_routes_t dmaRoutes,
  // pins and events
  output logic highDrivePinEnable,
  output logic [2:0] lcdDecapSelect,
  output logic parityNmi,
  output logic [3:0] timerBreak
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [3:0] byteParity(input logic [31:0] d);
    byteParity = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
  endfunction : byteParity

  function automatic logic [4:0] routeOne(input logic req, input logic sel, input int a, input int b);
    logic [4:0] r;
    r = 5'h00;
    r[sel ? b : a] = req;
    routeOne = r;
  endfunction : routeOne

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and boot latch

  logic [1:0] bootPinSync_reg;
  logic [1:0] altSync_reg;
  logic [1:0] paritySync_reg;
  logic [2:0] edgeCount_reg;
  logic bootPin_reg;
  logic bootAlt_reg;
  logic parityEnable_reg;

  always_ff @(posedge clk)
  begin
    if (clkEnable)
    begin
      bootPinSync_reg <= {bootPinSync_reg[0], bootSelectPin};
      altSync_reg <= {altSync_reg[0], bootAltOptionBit};
      paritySync_reg <= {paritySync_reg[0], parityCheckOption};
    end
  end

  // strap catch counts real clock edges, so not gated by clkEnable
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      edgeCount_reg <= 3'h0;
    end
    else if (edgeCount_reg != `BOOT_LATCH_EDGE)
    begin
      edgeCount_reg <= edgeCount_reg + 3'h1;
    end
  end

  wire latchNow = !reset && (edgeCount_reg == (`BOOT_LATCH_EDGE - 3'h1));

  always_ff @(posedge clk)
  begin
    if (latchNow)
    begin
      bootPin_reg <= bootPinSync_reg[1];
      bootAlt_reg <= altSync_reg[1];
      parityEnable_reg <= paritySync_reg[1];
    end
  end

  wire bootSecondSelector = ~bootAlt_reg;
  wire [1:0] bootStatus = {bootSecondSelector, bootPin_reg};
  wire latched = (edgeCount_reg == `BOOT_LATCH_EDGE);
  boot_source_t bootSource;
  assign bootSource = !bootPin_reg ? BOOT_MAIN_FLASH :
                      (bootSecondSelector ? BOOT_ONCHIP_SRAM : BOOT_SYSTEM_MEMORY);

  ////////////////////////////////////////////////////////////////////////////
  // boot alias decode

  wire inBootSpace = (memReq.addr[31:27] == 5'h00);
  wire inSram = (memReq.addr[31:13] == `SRAM_BASE >> 13);
  wire aliasSram = inBootSpace && (bootSource == BOOT_ONCHIP_SRAM);
  wire [31:0] aliasBase = (bootSource == BOOT_SYSTEM_MEMORY) ? `SYSTEM_MEMORY_BASE : `MAIN_FLASH_BASE;

  // offsets 0 and 4 map straight through, giving stack then start vector
  assign flashAddr = inBootSpace ? (aliasBase + {5'h00, memReq.addr[26:0]}) : memReq.addr;
  assign flashSelect = memReq.valid && latched && !inSram && !aliasSram;
  assign sramSelect = memReq.valid && latched && (inSram || aliasSram);

  ////////////////////////////////////////////////////////////////////////////
  // sram with byte parity

  logic [35:0] sramMem [`SRAM_WORDS];
  logic [`SRAM_INDEX_WIDTH-1:0] sramIndex;
  logic [35:0] readWord_reg;
  logic readPending_reg;
  assign sramIndex = memReq.addr[`SRAM_INDEX_WIDTH+1:2];
  wire [3:0] writeParity = byteParity(memReq.wdata);

  always_ff @(posedge clk)
  begin
    if (clkEnable && sramSelect && memReq.write)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (memReq.strobe[b])
        begin
          sramMem[sramIndex][b*8 +: 8] <= memReq.wdata[b*8 +: 8];
          sramMem[sramIndex][32 + b] <= writeParity[b];
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      readPending_reg <= 1'b0;
      readWord_reg <= 36'h0_0000_0000;
    end
    else if (clkEnable)
    begin
      readPending_reg <= sramSelect && !memReq.write;
      if (sramSelect && !memReq.write)
      begin
        readWord_reg <= sramMem[sramIndex];
      end
    end
  end

  assign memRdata = readWord_reg[31:0];
  assign memRvalid = readPending_reg;
  // untouched words hold unknown parity, hence software fill advice
  wire parityFail = readPending_reg && (byteParity(readWord_reg[31:0]) != readWord_reg[35:32]);

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] cfgZero_reg;
  logic [31:0] cfgOne_reg;
  logic parityLink_reg;
  logic parityFlag_reg;
  logic awTaken_reg;
  logic wTaken_reg;
  logic [31:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bValid_reg;
  logic [1:0] bResp_reg;
  logic rValid_reg;
  logic [31:0] rData_reg;
  logic [1:0] rResp_reg;

  wire awFire = busReq.awvalid && !awTaken_reg && !bValid_reg;
  wire wFire = busReq.wvalid && !wTaken_reg && !bValid_reg;
  wire haveAw = awTaken_reg || awFire;
  wire haveW = wTaken_reg || wFire;
  wire [31:0] curAwAddr = awTaken_reg ? awAddr_reg : busReq.awaddr;
  wire [31:0] curWData = wTaken_reg ? wData_reg : busReq.wdata;
  wire [3:0] curWStrb = wTaken_reg ? wStrb_reg : busReq.wstrb;
  wire doWrite = haveAw && haveW && !bValid_reg;
  wire fullWord = (curWStrb == 4'hF);

  wire wrZero = doWrite && fullWord && (curAwAddr[31:2] == 30'(`CFG_ZERO_OFFSET >> 2));
  wire wrOne = doWrite && fullWord && (curAwAddr[31:2] == 30'(`CFG_ONE_OFFSET >> 2));
  wire wrTwo = doWrite && fullWord && (curAwAddr[31:2] == 30'(`CFG_TWO_OFFSET >> 2));
  wire wrHit = (curAwAddr[31:2] <= 30'(`CFG_TWO_OFFSET >> 2));

  wire parityEvent = parityFail && parityEnable_reg;
  wire flagClear = wrTwo && curWData[`CFG2_PARITY_FLAG_BIT];

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cfgZero_reg <= `CFG_RESET_VALUE;
      cfgOne_reg <= `CFG_RESET_VALUE;
      parityLink_reg <= 1'b0;
      parityFlag_reg <= 1'b0;
    end
    else if (clkEnable)
    begin
      if (wrZero)
      begin
        cfgZero_reg <= curWData & `CFG0_WRITE_MASK;
      end
      if (wrOne)
      begin
        cfgOne_reg <= curWData & `CFG1_WRITE_MASK;
      end
      if (wrTwo)
      begin
        parityLink_reg <= curWData[`CFG2_PARITY_LINK_BIT];
      end
      // a new failure wins over a clear in the same cycle
      if (parityEvent)
      begin
        parityFlag_reg <= 1'b1;
      end
      else if (flagClear)
      begin
        parityFlag_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      awTaken_reg <= 1'b0;
      wTaken_reg <= 1'b0;
      awAddr_reg <= 32'h0000_0000;
      wData_reg <= 32'h0000_0000;
      wStrb_reg <= 4'h0;
      bValid_reg <= 1'b0;
      bResp_reg <= 2'h0;
    end
    else if (clkEnable)
    begin
      if (doWrite)
      begin
        awTaken_reg <= 1'b0;
        wTaken_reg <= 1'b0;
        bValid_reg <= 1'b1;
        bResp_reg <= (wrHit && fullWord) ? 2'h0 : 2'h2;
      end
      else
      begin
        if (awFire)
        begin
          awTaken_reg <= 1'b1;
          awAddr_reg <= busReq.awaddr;
        end
        if (wFire)
        begin
          wTaken_reg <= 1'b1;
          wData_reg <= busReq.wdata;
          wStrb_reg <= busReq.wstrb;
        end
        if (bValid_reg && busReq.bready)
        begin
          bValid_reg <= 1'b0;
        end
      end
    end
  end

  wire arFire = busReq.arvalid && !rValid_reg;
  wire [31:0] cfgZeroView = cfgZero_reg | {30'h0000_0000, bootStatus};
  wire [31:0] cfgTwoView = {23'h00_0000, parityFlag_reg, 6'h00, parityLink_reg, 1'b0};
  wire [31:0] readMux = (busReq.araddr[31:2] == 30'(`CFG_ZERO_OFFSET >> 2)) ? cfgZeroView :
                        (busReq.araddr[31:2] == 30'(`CFG_ONE_OFFSET >> 2)) ? cfgOne_reg :
                        (busReq.araddr[31:2] == 30'(`CFG_TWO_OFFSET >> 2)) ? cfgTwoView : 32'h0000_0000;
  wire rdHit = (busReq.araddr[31:2] <= 30'(`CFG_TWO_OFFSET >> 2));

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rValid_reg <= 1'b0;
      rData_reg <= 32'h0000_0000;
      rResp_reg <= 2'h0;
    end
    else if (clkEnable)
    begin
      if (arFire)
      begin
        rValid_reg <= 1'b1;
        rData_reg <= readMux;
        rResp_reg <= rdHit ? 2'h0 : 2'h2;
      end
      else if (rValid_reg && busReq.rready)
      begin
        rValid_reg <= 1'b0;
      end
    end
  end

  assign busRsp.awready = clkEnable && awFire;
  assign busRsp.wready = clkEnable && wFire;
  assign busRsp.bvalid = bValid_reg;
  assign busRsp.bresp = bResp_reg;
  assign busRsp.arready = clkEnable && arFire;
  assign busRsp.rvalid = rValid_reg;
  assign busRsp.rdata = rData_reg;
  assign busRsp.rresp = rResp_reg;

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign highDrivePinEnable = cfgZero_reg[`CFG0_HIGH_DRIVE_BIT];
  assign lcdDecapSelect = cfgOne_reg[3:1];
  assign dmaRoutes.timerSixteenCh = routeOne(timerSixteenReq, cfgZero_reg[`CFG0_TIMER_SIXTEEN_BIT], 0, 1);
  assign dmaRoutes.timerFifteenCh = routeOne(timerFifteenReq, cfgZero_reg[`CFG0_TIMER_FIFTEEN_BIT], 2, 3);
  assign dmaRoutes.serialRxCh = routeOne(serialRxReq, cfgZero_reg[`CFG0_SERIAL_RX_BIT], 2, 4);
  assign dmaRoutes.serialTxCh = routeOne(serialTxReq, cfgZero_reg[`CFG0_SERIAL_TX_BIT], 1, 3);
  assign dmaRoutes.converterCh = routeOne(converterReq, cfgZero_reg[`CFG0_CONVERTER_BIT], 0, 1);
  assign parityNmi = parityFlag_reg;
  assign timerBreak = {4{parityFlag_reg && parityLink_reg}};

endmodule : sys_config_boot_remap

/* File: tb/sys_config_monitor.sv */
`timescale 1ns/100ps
`include "sys_config_defines.svh"
module sys_config_monitor
  import sys_config_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clkEnable,
  // memory port
  input wire sram_req_t memReq,
  input wire logic memRvalid,
  input wire logic [31:0] flashAddr,
  input wire logic flashSelect,
  input wire logic sramSelect,
  // events
  input wire logic parityNmi,
  input wire logic [3:0] timerBreak
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic readReq = memReq.valid && !memReq.write && sramSelect && clkEnable;
  wire logic bootSpace = flashSelect && memReq.addr[31:27] == 5'h00;
  ////////////////////////////////////////////////////////////
  sequence s_readTaken;
    readReq;
  endsequence
  sequence s_selectsIdle;
    !flashSelect && !sramSelect;
  endsequence
  property p_readAnswer;
    s_readTaken |=> memRvalid;
  endproperty
  a_readAnswer: assert property (p_readAnswer) else $error("sram read not answered");
  property p_noSpurious;
    memRvalid |-> $past(readReq);
  endproperty
  a_noSpurious: assert property (p_noSpurious) else $error("read data without request");
  property p_breakAll;
    timerBreak == 4'h0 || timerBreak == 4'hF;
  endproperty
  a_breakAll: assert property (p_breakAll) else $error("break lines disagree");
  property p_breakNeedsFlag;
    timerBreak != 4'h0 |-> parityNmi;
  endproperty
  a_breakNeedsFlag: assert property (p_breakNeedsFlag) else $error("break without flag");
  // flag may only rise one or two cycles after a read answer
  property p_flagCause;
    $rose(parityNmi) |-> $past(memRvalid) || $past(memRvalid, 2);
  endproperty
  a_flagCause: assert property (p_flagCause) else $error("nmi without sram read");
  property p_selExclusive;
    !(flashSelect && sramSelect);
  endproperty
  a_selExclusive: assert property (p_selExclusive) else $error("two memories selected");
  property p_aliasBase;
    bootSpace |-> flashAddr == memReq.addr + `MAIN_FLASH_BASE || flashAddr == memReq.addr + `SYSTEM_MEMORY_BASE;
  endproperty
  a_aliasBase: assert property (p_aliasBase) else $error("boot alias base wrong");
  property p_bootWait;
    $fell(reset) |-> s_selectsIdle [*3];
  endproperty
  a_bootWait: assert property (p_bootWait) else $error("boot source used before latch");
endmodule : sys_config_monitor

bind sys_config_boot_remap sys_config_monitor mon (.clk, .reset, .clkEnable, .memReq, .memRvalid,
  .flashAddr, .flashSelect, .sramSelect, .parityNmi, .timerBreak);

/* File: tb/bus_fabric_model.sv */
`timescale 1ns/100ps
module bus_fabric_model
  import sys_config_pkg::*;
(
  // clock
  input wire logic clk,
  // processor memory port
  output sram_req_t memReq,
  input wire logic [31:0] memRdata,
  input wire logic memRvalid,
  input wire logic [31:0] flashAddr,
  input wire logic flashSelect
);
  initial memReq = '0;
  ////////////////////////////////////////////////////////////
  // flash hits return the translated address, since no flash sits here
  task automatic access(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] q);
    logic [31:0] fa;
    memReq <= '{addr: a, strobe: s, write: w, valid: 1'h1, wdata: d};
    @(posedge clk);
    // routing as it stands at the edge that takes the request
    fa = flashSelect ? flashAddr : 32'h0000_0000;
    memReq.valid <= 1'h0;
    // released lines must not look like the last request
    memReq.addr <= ~a;
    memReq.wdata <= ~d;
    // read data was launched by the taking edge, settled by the next one
    @(posedge clk);
    q = memRvalid ? memRdata : fa;
  endtask : access
endmodule : bus_fabric_model

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "sys_config_defines.svh"
module tb
  import sys_config_pkg::*;
;
  logic clk, reset, clkEnable, bootSelectPin, bootAltOptionBit, parityCheckOption;
  logic [4:0] dmaReq;
  axil_req_t busReq;
  axil_rsp_t busRsp;
  sram_req_t memReq;
  logic [31:0] memRdata, flashAddr;
  logic memRvalid, flashSelect, sramSelect, highDrivePinEnable, parityNmi;
  dma_routes_t dmaRoutes;
  logic [2:0] lcdDecapSelect;
  logic [3:0] timerBreak;
  int errCount = 0;
  int nChecks = 0;

  sys_config_boot_remap DUT (.clk, .reset, .clkEnable, .bootSelectPin, .bootAltOptionBit,
    .parityCheckOption, .busReq, .busRsp, .memReq, .memRdata, .memRvalid, .flashAddr,
    .flashSelect, .sramSelect, .timerSixteenReq(dmaReq[4]), .timerFifteenReq(dmaReq[3]),
    .serialRxReq(dmaReq[2]), .serialTxReq(dmaReq[1]), .converterReq(dmaReq[0]), .dmaRoutes,
    .highDrivePinEnable, .lcdDecapSelect, .parityNmi, .timerBreak);
  bus_fabric_model fab (.clk, .memReq, .memRdata, .memRvalid, .flashAddr, .flashSelect);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic [1:0] r);
    logic t;
    t = 1'h0;
    busReq.awaddr <= a;
    busReq.araddr <= a;
    busReq.wdata <= d;
    busReq.wstrb <= 4'hF;
    busReq.awvalid <= w;
    busReq.wvalid <= w;
    busReq.bready <= w;
    busReq.arvalid <= !w;
    busReq.rready <= !w;
    while (!t)
    begin
      @(posedge clk);
      if (busRsp.awready) busReq.awvalid <= 1'h0;
      if (busRsp.wready) busReq.wvalid <= 1'h0;
      if (busRsp.arready) busReq.arvalid <= 1'h0;
      if (busRsp.bvalid || busRsp.rvalid)
      begin
        q = busRsp.rdata;
        r = w ? busRsp.bresp : busRsp.rresp;
        busReq.bready <= 1'h0;
        busReq.rready <= 1'h0;
        t = 1'h1;
      end
    end
    @(posedge clk);
  endtask : axi

  task automatic boot_test;
    logic [31:0] q, e;
    logic [1:0] r;
    logic p, n;
    for (int i = 0; i < 3; i++)
    begin
      p = (i != 1);
      n = (i != 2);
      bootSelectPin <= p;
      bootAltOptionBit <= n;
      reset <= 1'h1;
      repeat (5) @(posedge clk);
      reset <= 1'h0;
      repeat (8) @(posedge clk);
      // a late pin change must not move the latched selection
      bootSelectPin <= ~p;
      axi(1'h0, 32'h0000_0000, 32'h0000_0000, q, r);
      chk("bootStatus", q, {30'h0, ~n, p});
      axi(1'h0, 32'h0000_0004, 32'h0000_0000, q, r);
      chk("cfgOneReset", q, `CFG_RESET_VALUE);
      fab.access(1'h1, `SRAM_BASE, 32'h1111_2222, 4'hF, q);
      fab.access(1'h1, `SRAM_BASE + 32'h4, 32'h3333_4444, 4'hF, q);
      for (int j = 0; j < 2; j++)
      begin
        fab.access(1'h0, {29'h0, j[0], 2'h0}, 32'h0000_0000, 4'hF, q);
        e = (i == 0) ? `SYSTEM_MEMORY_BASE : `MAIN_FLASH_BASE;
        e = (i == 2) ? (j[0] ? 32'h3333_4444 : 32'h1111_2222) : e + {29'h0, j[0], 2'h0};
        chk("bootFetch", q, e);
      end
    end
    $display("boot_test done");
  endtask : boot_test

  task automatic reg_test;
    logic [31:0] q;
    logic [1:0] r;
    axi(1'h1, 32'h0000_0000, 32'h0008_1F00, q, r);
    chk("cfgZeroResp", {30'h0, r}, 32'h0000_0000);
    axi(1'h0, 32'h0000_0000, 32'h0000_0000, q, r);
    chk("cfgZero", q, 32'h0008_1F03);
    chk("highDrive", {31'h0, highDrivePinEnable}, 32'h0000_0001);
    axi(1'h1, 32'h0000_0004, 32'h0000_000E, q, r);
    chk("lcdAll", {29'h0, lcdDecapSelect}, 32'h0000_0007);
    axi(1'h1, 32'h0000_0004, 32'h0000_0004, q, r);
    chk("lcdOne", {29'h0, lcdDecapSelect}, 32'h0000_0002);
    axi(1'h1, 32'h0000_0000, 32'h0000_0000, q, r);
    chk("highDriveOff", {31'h0, highDrivePinEnable}, 32'h0000_0000);
    axi(1'h1, 32'h0000_0010, 32'h0000_0001, q, r);
    chk("holeWrResp", {30'h0, r}, 32'h0000_0002);
    axi(1'h0, 32'h0000_0010, 32'h0000_0000, q, r);
    chk("holeRd", q, 32'h0000_0000);
    chk("holeRdResp", {30'h0, r}, 32'h0000_0002);
    $display("reg_test done");
  endtask : reg_test

  task automatic dma_test;
    logic [31:0] q;
    logic [1:0] r;
    dmaReq <= 5'h1F;
    for (int v = 0; v < 2; v++)
    begin
      axi(1'h1, 32'h0000_0000, v ? 32'h0000_1F00 : 32'h0000_0000, q, r);
      chk("dmaRoutes", {7'h0, dmaRoutes}, v ? {7'h0, 5'h02, 5'h08, 5'h10, 5'h08, 5'h02} :
        {7'h0, 5'h01, 5'h04, 5'h04, 5'h02, 5'h01});
    end
    dmaReq <= 5'h00;
    $display("dma_test done");
  endtask : dma_test

  task automatic parity_test;
    logic [31:0] q;
    logic [1:0] r;
    axi(1'h1, 32'h0000_0008, 32'h0000_0102, q, r);
    axi(1'h0, 32'h0000_0008, 32'h0000_0000, q, r);
    chk("parityCtl", q, 32'h0000_0002);
    fab.access(1'h1, `SRAM_BASE + 32'h10, 32'h0123_4567, 4'hF, q);
    fab.access(1'h1, `SRAM_BASE + 32'h10, 32'h0000_00AA, 4'h1, q);
    fab.access(1'h1, `SRAM_BASE + 32'h10, 32'hBEEF_0000, 4'hC, q);
    fab.access(1'h0, `SRAM_BASE + 32'h10, 32'h0000_0000, 4'hF, q);
    chk("sramMerge", q, 32'hBEEF_45AA);
    repeat (2) @(posedge clk);
    chk("parityNmi", {31'h0, parityNmi}, 32'h0000_0000);
    chk("timerBreak", {28'h0, timerBreak}, 32'h0000_0000);
    $display("parity_test done");
  endtask : parity_test

  task automatic finish_test;
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    reset = 1'h1;
    clkEnable = 1'h1;
    bootSelectPin = 1'h0;
    bootAltOptionBit = 1'h1;
    parityCheckOption = 1'h1;
    dmaReq = 5'h00;
    busReq = '0;
    @(posedge clk);
    boot_test;
    reg_test;
    dma_test;
    parity_test;
    finish_test;
  end

  // the whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    errCount++;
    finish_test;
  end
endmodule : tb
